// [hdl/ddrin_pkg.sv]
// Notes on behaviour
// - Hold CKE and ODT low during ramp.
// - Clock runs stable 200 us first.
// - Drive NOP, then raise CKE.
// - NOP 400 ns, then precharge all.
// - Program EMR2 with BA=010.
// - Program EMR3 with BA=011.
// - EMR1 enables DLL, A0 and A9..A7 low.
// - MR write with A8 high resets DLL.
// - Precharge all, then two or more refreshes.
// - MR rewrite with A8 low.
// - 200 clocks later, calibration default then exit.
// - MR holds burst, latency, DLL reset, recovery.
// - EMR writes set DLL, drive, latency, termination.
// - Every register write carries all fields.
// - MR write is all strobes low, BA zero.
// - MR undefined at power-up; must program.
// - Mode writes need precharged banks, CKE high.
// - Wait mode-set cycle time after writes.
// - Wait 200 clocks after DLL reset before reads.
// - EMR1 writes otherwise carry 000 calibration.
package ddrin_pkg;

  // Register map, byte addresses on the Wishbone slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MR = 8'h08;
  localparam logic [7:0] ADDR_EMR1 = 8'h0c;
  localparam logic [7:0] ADDR_EMR2 = 8'h10;
  localparam logic [7:0] ADDR_EMR3 = 8'h14;

  // Control and status fields
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_STATE_LSB = 16;
  localparam int MODE_W = 13;

  // Reset values of the mode shadows: BL4, CL3, WR2, DLL enabled
  localparam logic [12:0] MR_RST = 13'h0232;
  localparam logic [12:0] EMR1_RST = 13'h0000;
  localparam logic [12:0] EMR2_RST = 13'h0000;
  localparam logic [12:0] EMR3_RST = 13'h0000;

  // Mode register field positions
  localparam int MR_DLL_RST_BIT = 8;
  localparam int MR_TEST_BIT = 7;
  localparam int EMR1_DLL_DIS_BIT = 0;
  localparam int EMR1_CAL_LSB = 7;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam int ADDR_AP_BIT = 10;

  // Bank codes selecting the mode registers
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;

  // Timing figures in their own units
  localparam int T_CLK_NS = 50;
  localparam int CK_DIV = 2;
  localparam int T_CK_NS = T_CLK_NS * CK_DIV;
  localparam int T_STABLE_US = 200;
  localparam int T_CKE_NS = 400;
  localparam int DLL_LOCK_CK = 200;
  localparam int REF_MIN = 2;
  localparam int STABLE_TK = (T_STABLE_US * 1000 + T_CK_NS - 1) / T_CK_NS;
  localparam int CKE_TK = (T_CKE_NS + T_CK_NS - 1) / T_CK_NS;

  // Command bus to the memory
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] a;
  } ddrin_cmd_t;

  // Initialization sequence steps
  typedef enum logic [14:0] {
    ST_IDLE = 15'h0001,
    ST_CLK = 15'h0002,
    ST_PRE1 = 15'h0004,
    ST_EMR2 = 15'h0008,
    ST_EMR3 = 15'h0010,
    ST_EMR1 = 15'h0020,
    ST_MRDLL = 15'h0040,
    ST_PRE2 = 15'h0080,
    ST_REF = 15'h0100,
    ST_MRRUN = 15'h0200,
    ST_DLLW = 15'h0400,
    ST_CALDEF = 15'h0800,
    ST_CALEXIT = 15'h1000,
    ST_DONE = 15'h2000,
    ST_SPARE = 15'h4000
  } ddrin_state_t;

endpackage

// [hdl/ddrin_ctrl.sv]
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module ddrin_ctrl
  import ddrin_pkg::*;
#(
  parameter int STABLE_CK = STABLE_TK,
  parameter int TMRD_CK = 2,
  parameter int T_RP_NS = 15,
  parameter int T_RFC_NS = 128,
  parameter int REF_COUNT = REF_MIN
)
(
  // System clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Memory clock pair
  output logic DDR_CK,
  output logic DDR_CK_N,
  // Memory command and address bus
  output logic DDR_CKE,
  output logic DDR_ODT,
  output logic DDR_CS_N,
  output logic DDR_RAS_N,
  output logic DDR_CAS_N,
  output logic DDR_WE_N,
  output logic [2:0] DDR_BA,
  output logic [14:0] DDR_A
);

  // Derived interval counts in memory clock ticks
  localparam int RP_TK = (T_RP_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int RFC_TK = (T_RFC_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] STABLE_W = CNT_W'(STABLE_CK);
  localparam logic [CNT_W-1:0] CKE_W = CNT_W'(CKE_TK);
  localparam logic [CNT_W-1:0] MRD_W = CNT_W'(TMRD_CK - 1);
  localparam logic [CNT_W-1:0] RP_W = CNT_W'(RP_TK < 1 ? 0 : RP_TK - 1);
  localparam logic [CNT_W-1:0] RFC_W = CNT_W'(RFC_TK < 1 ? 0 : RFC_TK - 1);
  localparam logic [7:0] DLL_W = 8'(DLL_LOCK_CK);
  localparam logic [7:0] REF_LAST = 8'(REF_COUNT - 1);

  // Sequencer state
  ddrin_state_t state_r;
  ddrin_cmd_t cmd_r;
  logic [CNT_W-1:0] wait_r;
  logic [7:0] dll_cnt_r;
  logic [7:0] ref_cnt_r;
  logic done_r;
  logic ck_r;
  logic tick;

  // Software shadows of the mode registers
  logic [MODE_W-1:0] mr_r;
  logic [MODE_W-1:0] emr1_r;
  logic [MODE_W-1:0] emr2_r;
  logic [MODE_W-1:0] emr3_r;

  // Bus side
  logic [31:0] rdat_r;
  logic req;
  logic wr;
  logic start;

  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr = req & WB_WE_I;
  assign start = wr & WB_SEL_I[0] & (WB_ADR_I == ADDR_CTRL) & WB_DAT_I[CTRL_START_BIT];

  // Byte lane merge for the 13-bit mode shadows
  function automatic logic [MODE_W-1:0] lane_merge(
    input logic [MODE_W-1:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [MODE_W-1:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      res[MODE_W-1:8] = dat[MODE_W-1:8];
    end
    return res;
  endfunction

  // Build a mode register write; A14..A13 always low, whole value sent
  function automatic ddrin_cmd_t mode_cmd(
    input logic [2:0] ba,
    input logic [MODE_W-1:0] val
  );
    ddrin_cmd_t c;
    c.cke = 1'b1;
    c.cs_n = 1'b0;
    c.ras_n = 1'b0;
    c.cas_n = 1'b0;
    c.we_n = 1'b0;
    c.ba = ba;
    c.a = {2'h0, val};
    return c;
  endfunction

  // Idle bus cycle with clock enable held as given
  function automatic ddrin_cmd_t nop_cmd(input logic cke);
    ddrin_cmd_t c;
    c.cke = cke;
    c.cs_n = 1'b0;
    c.ras_n = 1'b1;
    c.cas_n = 1'b1;
    c.we_n = 1'b1;
    c.ba = 3'h0;
    c.a = 15'h0000;
    return c;
  endfunction

  // Precharge of every bank, A10 high
  function automatic ddrin_cmd_t prea_cmd();
    ddrin_cmd_t c;
    c = nop_cmd(1'b1);
    c.ras_n = 1'b0;
    c.we_n = 1'b0;
    c.a[ADDR_AP_BIT] = 1'b1;
    return c;
  endfunction

  // Auto refresh
  function automatic ddrin_cmd_t ref_cmd();
    ddrin_cmd_t c;
    c = nop_cmd(1'b1);
    c.ras_n = 1'b0;
    c.cas_n = 1'b0;
    return c;
  endfunction

  // Memory clock divider; commands change only as the clock falls
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ck_r <= 1'b0;
    end
    else
    begin
      ck_r <= ~ck_r;
    end
  end

  assign tick = ck_r;

  // Clock pair and termination outputs; termination is never used here
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      DDR_CK <= 1'b0;
      DDR_CK_N <= 1'b1;
      DDR_ODT <= 1'b0;
    end
    else
    begin
      DDR_CK <= ~ck_r;
      DDR_CK_N <= ck_r;
      DDR_ODT <= 1'b0;
    end
  end

  // Shadow writes; only the byte lanes selected by WB_SEL_I are replaced
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mr_r <= MR_RST;
      emr1_r <= EMR1_RST;
      emr2_r <= EMR2_RST;
      emr3_r <= EMR3_RST;
    end
    else if (wr)
    begin
      unique case (WB_ADR_I)
        ADDR_MR: mr_r <= lane_merge(mr_r, WB_DAT_I, WB_SEL_I);
        ADDR_EMR1: emr1_r <= lane_merge(emr1_r, WB_DAT_I, WB_SEL_I);
        ADDR_EMR2: emr2_r <= lane_merge(emr2_r, WB_DAT_I, WB_SEL_I);
        ADDR_EMR3: emr3_r <= lane_merge(emr3_r, WB_DAT_I, WB_SEL_I);
        default: ;
      endcase
    end
  end

  // Read mux, registered; unmapped words read zero
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rdat_r <= 32'h0000_0000;
    end
    else if (req)
    begin
      rdat_r <= 32'h0000_0000;
      unique case (WB_ADR_I)
        ADDR_STATUS:
        begin
          rdat_r[STAT_BUSY_BIT] <= ~done_r & (state_r != ST_IDLE);
          rdat_r[STAT_DONE_BIT] <= done_r;
          rdat_r[STAT_STATE_LSB +: 15] <= state_r;
        end
        ADDR_MR: rdat_r[MODE_W-1:0] <= mr_r;
        ADDR_EMR1: rdat_r[MODE_W-1:0] <= emr1_r;
        ADDR_EMR2: rdat_r[MODE_W-1:0] <= emr2_r;
        ADDR_EMR3: rdat_r[MODE_W-1:0] <= emr3_r;
        default: ;
      endcase
    end
  end

  // Bus answer one cycle after the request, dropped after one
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      WB_ACK_O <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    end
  end

  assign WB_DAT_O = rdat_r;

  // Ticks since the DLL reset write, saturating
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      dll_cnt_r <= 8'h00;
    end
    else if (tick && state_r == ST_MRDLL && wait_r == '0)
    begin
      dll_cnt_r <= 8'h00;
    end
    else if (tick && dll_cnt_r != 8'hff)
    begin
      dll_cnt_r <= dll_cnt_r + 8'h01;
    end
  end

  // Init sequencer; a start during a run restarts it, data is kept
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_r <= ST_IDLE;
      cmd_r <= nop_cmd(1'b0);
      wait_r <= '0;
      ref_cnt_r <= 8'h00;
      done_r <= 1'b0;
    end
    else if (start)
    begin
      // Clock already runs; count its stable time with CKE low
      // Bus moves only on a tick so a command never loses half its period
      state_r <= ST_CLK;
      cmd_r <= tick ? nop_cmd(1'b0) : cmd_r;
      wait_r <= STABLE_W;
      done_r <= 1'b0;
    end
    else if (tick)
    begin
      if (wait_r != '0)
      begin
        // Only NOP between steps; CKE low through the stable wait
        wait_r <= wait_r - CNT_W'(1);
        cmd_r <= nop_cmd(cmd_r.cke && state_r != ST_CLK);
      end
      else
      begin
        unique case (state_r)
          ST_IDLE: cmd_r <= nop_cmd(cmd_r.cke);
          ST_CLK:
          begin
            cmd_r <= nop_cmd(1'b1);
            wait_r <= CKE_W;
            state_r <= ST_PRE1;
          end
          ST_PRE1:
          begin
            cmd_r <= prea_cmd();
            wait_r <= RP_W;
            state_r <= ST_EMR2;
          end
          ST_EMR2:
          begin
            cmd_r <= mode_cmd(BA_EMR2, emr2_r);
            wait_r <= MRD_W;
            state_r <= ST_EMR3;
          end
          ST_EMR3:
          begin
            cmd_r <= mode_cmd(BA_EMR3, emr3_r);
            wait_r <= MRD_W;
            state_r <= ST_EMR1;
          end
          ST_EMR1:
          begin
            // DLL on, calibration field cleared, other fields as set
            cmd_r <= mode_cmd(BA_EMR1, {emr1_r[12:10], CAL_EXIT,
                               emr1_r[6:1], 1'b0});
            wait_r <= MRD_W;
            state_r <= ST_MRDLL;
          end
          ST_MRDLL:
          begin
            cmd_r <= mode_cmd(BA_MR, {mr_r[MODE_W-1:MR_DLL_RST_BIT+1], 1'b1,
                               1'b0, mr_r[6:0]});
            wait_r <= MRD_W;
            state_r <= ST_PRE2;
          end
          ST_PRE2:
          begin
            cmd_r <= prea_cmd();
            wait_r <= RP_W;
            ref_cnt_r <= 8'h00;
            state_r <= ST_REF;
          end
          ST_REF:
          begin
            cmd_r <= ref_cmd();
            wait_r <= RFC_W;
            ref_cnt_r <= ref_cnt_r + 8'h01;
            if (ref_cnt_r >= REF_LAST)
            begin
              state_r <= ST_MRRUN;
            end
          end
          ST_MRRUN:
          begin
            // Test mode forced low for normal operation
            cmd_r <= mode_cmd(BA_MR, {mr_r[MODE_W-1:MR_DLL_RST_BIT+1], 1'b0,
                               1'b0, mr_r[6:0]});
            wait_r <= MRD_W;
            state_r <= ST_DLLW;
          end
          ST_DLLW:
          begin
            cmd_r <= nop_cmd(1'b1);
            if (dll_cnt_r >= DLL_W)
            begin
              state_r <= ST_CALDEF;
            end
          end
          ST_CALDEF:
          begin
            cmd_r <= mode_cmd(BA_EMR1, {emr1_r[12:10], CAL_DEFAULT,
                               emr1_r[6:1], 1'b0});
            wait_r <= MRD_W;
            state_r <= ST_CALEXIT;
          end
          ST_CALEXIT:
          begin
            cmd_r <= mode_cmd(BA_EMR1, {emr1_r[12:10], CAL_EXIT,
                               emr1_r[6:1], 1'b0});
            wait_r <= MRD_W;
            state_r <= ST_DONE;
          end
          ST_DONE:
          begin
            cmd_r <= nop_cmd(1'b1);
            done_r <= 1'b1;
          end
          default:
          begin
            state_r <= ST_IDLE;
            cmd_r <= nop_cmd(1'b0);
          end
        endcase
      end
    end
  end

  // Pin drivers straight from the command flop
  assign DDR_CKE = cmd_r.cke;
  assign DDR_CS_N = cmd_r.cs_n;
  assign DDR_RAS_N = cmd_r.ras_n;
  assign DDR_CAS_N = cmd_r.cas_n;
  assign DDR_WE_N = cmd_r.we_n;
  assign DDR_BA = cmd_r.ba;
  assign DDR_A = cmd_r.a;

endmodule

// [verification/ddrin_ctrl_sva.sv]
`timescale 1ns/1ps
module ddrin_ctrl_sva
  import ddrin_pkg::*;
#(
  parameter int STABLE_CK = STABLE_TK
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register bus handshake
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Memory side
  input wire logic DDR_CK,
  input wire logic DDR_CKE,
  input wire logic DDR_ODT,
  input wire logic DDR_CS_N,
  input wire logic DDR_RAS_N,
  input wire logic DDR_CAS_N,
  input wire logic DDR_WE_N,
  input wire logic [2:0] DDR_BA,
  input wire logic [14:0] DDR_A
);
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic cmd_v;
  logic mrs_v;
  logic acc_v;
  logic [24:0] bus_w;

  // Command decode; reads, writes and activates are all banned here
  assign cmd_v = !DDR_CS_N && !(DDR_RAS_N && DDR_CAS_N && DDR_WE_N);
  assign mrs_v = cmd_v && !DDR_RAS_N && !DDR_CAS_N && !DDR_WE_N;
  assign acc_v = cmd_v && (DDR_RAS_N ? !DDR_CAS_N : (DDR_CAS_N && DDR_WE_N));
  assign bus_w = {DDR_CKE, DDR_CS_N, DDR_RAS_N, DDR_CAS_N, DDR_WE_N, DDR_BA, DDR_A};

  // Cycles with clock enable low; saturates so long idles never wrap
  always_ff @(posedge CLK)
  begin
    if (SRST || DDR_CKE)
      low_r <= 16'h0000;
    else if (low_r != 16'hffff)
      low_r <= low_r + 16'h0001;
  end

  // Cycles with clock enable high
  always_ff @(posedge CLK)
  begin
    if (SRST || !DDR_CKE)
      high_r <= 16'h0000;
    else if (high_r != 16'hffff)
      high_r <= high_r + 16'h0001;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  AST_ODT_LOW: assert property (DDR_ODT == 1'b0)
    else $error("termination driven");
  AST_CKE_WAIT: assert property ($rose(DDR_CKE) |-> low_r >= 16'(2 * STABLE_CK - 2))
    else $error("clock enable raised early");
  AST_CKE_NOP: assert property ($rose(DDR_CKE) |-> !cmd_v)
    else $error("command at clock enable rise");
  AST_CMD_GAP: assert property (cmd_v |-> DDR_CKE && high_r >= 16'(2 * CKE_TK - 2))
    else $error("command too soon");
  AST_NO_ACCESS: assert property (!acc_v)
    else $error("array access during init");
  AST_MRS_CKE: assert property (mrs_v |-> DDR_CKE && $past(DDR_CKE, 2))
    else $error("mode write without clock enable");
  AST_MRS_TOP: assert property (mrs_v |-> !DDR_BA[2] && DDR_A[14:13] == 2'h0)
    else $error("mode write upper bits set");
  AST_MR_TEST: assert property (mrs_v && DDR_BA == BA_MR |-> !DDR_A[MR_TEST_BIT])
    else $error("test mode bit set");
  AST_DLL_ON: assert property (mrs_v && DDR_BA == BA_EMR1 |-> !DDR_A[EMR1_DLL_DIS_BIT])
    else $error("delay loop disabled");
  AST_CMD_HOLD: assert property ($rose(DDR_CK) |-> $stable(bus_w))
    else $error("command moved at memory clock rise");
  AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer late or long");

  // Main scenarios reached
  COV_CKE: cover property ($rose(DDR_CKE));
  COV_EMR2: cover property (mrs_v && DDR_BA == BA_EMR2);
  COV_REF: cover property (cmd_v && !DDR_RAS_N && !DDR_CAS_N && DDR_WE_N);
endmodule

bind ddrin_ctrl ddrin_ctrl_sva #(.STABLE_CK(STABLE_CK)) i_ddrin_ctrl_sva (
  .CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .DDR_CK(DDR_CK), .DDR_CKE(DDR_CKE), .DDR_ODT(DDR_ODT), .DDR_CS_N(DDR_CS_N),
  .DDR_RAS_N(DDR_RAS_N), .DDR_CAS_N(DDR_CAS_N), .DDR_WE_N(DDR_WE_N), .DDR_BA(DDR_BA),
  .DDR_A(DDR_A));

// [verification/ddrin_mem.sv]
`timescale 1ns/1ps
module ddrin_mem
  import ddrin_pkg::*;
(
  // Memory clock from the controller
  input wire logic ck,
  // Command bus with clock enable
  input wire ddrin_cmd_t cmd
);
  typedef struct packed {
    logic [2:0] op;
    logic [2:0] ba;
    logic [14:0] a;
    logic [31:0] tick;
  } ddrin_rec_t;

  ddrin_rec_t log_q[$];
  logic [31:0] tick_r = 32'h0000_0000;
  logic [14:0] mode_r [4];
  logic cal_def_r = 1'b0;
  logic ready_r = 1'b0;
  logic [2:0] op_w;

  assign op_w = {cmd.ras_n, cmd.cas_n, cmd.we_n};

  // Taken on the memory clock rise only; every command other than NOP or deselect is logged for the bench while CKE is high
  always @(posedge ck)
  begin
    tick_r <= tick_r + 32'h0000_0001;
    if (!cmd.cke)
      ready_r <= 1'b0;
    else if (!cmd.cs_n && op_w != 3'h7)
    begin
      log_q.push_back(ddrin_rec_t'{op_w, cmd.ba, cmd.a, tick_r});
      // Settings only; a restart leaves them and any stored data alone
      if (op_w == 3'h0 && !cmd.ba[2])
        mode_r[cmd.ba[1:0]] <= cmd.a;
      // Usable only once calibration default is followed by its exit
      if (op_w == 3'h0 && cmd.ba == BA_EMR1)
      begin
        cal_def_r <= cmd.a[9:7] == CAL_DEFAULT;
        ready_r <= cal_def_r && cmd.a[9:7] == CAL_EXIT;
      end
    end
  end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import ddrin_pkg::*;

  logic clk;
  logic srst;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic ack;
  logic ck;
  logic ck_n;
  logic odt;
  wire ddrin_cmd_t cmd;
  logic [31:0] rdv;
  logic [3:0] sel_v;
  int fails;
  int checks_done;
  int k;

  ddrin_ctrl #(.STABLE_CK(20)) i_ddrin_ctrl (
    .CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .DDR_CK(ck),
    .DDR_CK_N(ck_n), .DDR_CKE(cmd.cke), .DDR_ODT(odt), .DDR_CS_N(cmd.cs_n),
    .DDR_RAS_N(cmd.ras_n), .DDR_CAS_N(cmd.cas_n), .DDR_WE_N(cmd.we_n), .DDR_BA(cmd.ba),
    .DDR_A(cmd.a));

  ddrin_mem i_ddrin_mem (.ck(ck), .cmd(cmd));

  // 20 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One classic cycle; held until ack is seen, read data taken at that edge
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= sel_v;
    @(posedge clk);
    while (ack !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 16)
      fails++;
    rdv = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Poll status; bounded so a stuck sequence still ends the run
  task automatic wait_done;
    int n;
    n = 0;
    rdv = 32'h0;
    while (rdv[STAT_DONE_BIT] !== 1'b1 && n < 400)
    begin
      wb_xfer(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    chk("done", 32'h1, {31'h0, rdv[STAT_DONE_BIT]});
  endtask

  // Expected command order for the shadow values written below
  task automatic check_seq;
    logic [2:0] eop [11];
    logic [2:0] eba [11];
    logic [14:0] ea [11];
    logic [52:0] r;
    logic [31:0] t0;
    logic [31:0] t1;
    int n;
    eop = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
    eba = '{3'h0, BA_EMR2, BA_EMR3, BA_EMR1, BA_MR, 3'h0, 3'h0, 3'h0, BA_MR, BA_EMR1, BA_EMR1};
    ea = '{15'h0, 15'h0080, 15'h0, 15'h0408, 15'h0b42, 15'h0, 15'h0, 15'h0, 15'h0a42,
      15'h0788, 15'h0408};
    t0 = 32'h0;
    t1 = 32'h0;
    n = i_ddrin_mem.log_q.size();
    chk("commands", 32'd11, 32'(n));
    for (int i = 0; i < 11 && i < n; i++)
    begin
      r = i_ddrin_mem.log_q[i];
      chk("op", 32'(eop[i]), 32'(r[52:50]));
      if (eop[i] == 3'h0)
        chk("mode", {14'h0, eba[i], ea[i]}, {14'h0, r[49:32]});
      if (eop[i] == 3'h2)
        chk("all banks", 32'h1, {31'h0, r[32 + ADDR_AP_BIT]});
      if (i == 4)
        t0 = r[31:0];
      if (i == 9)
        t1 = r[31:0];
    end
    chk("lock wait", 32'h1, {31'h0, (t1 - t0) >= DLL_LOCK_CK});
  endtask

  // Hang guard, well beyond two full sequences
  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    test_done;
  end

  initial
  begin
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    sel_v = 4'hf;
    dat_w = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    chk("cke", 32'h0, {31'h0, cmd.cke});
    chk("odt", 32'h0, {31'h0, odt});
    // Register defaults, then an unmapped hole
    for (int i = 0; i < 6; i++)
    begin
      wb_xfer(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", i == 1 ? 32'h0001_0000 : (i == 2 ? 32'(MR_RST) : 32'h0), rdv);
    end
    wb_xfer(1'b1, 8'h40, 32'hffff_ffff);
    wb_xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdv);
    // Test bit and delay loop disable are set on purpose; both must be dropped
    wb_xfer(1'b1, ADDR_MR, 32'h0000_0ac2);
    wb_xfer(1'b1, ADDR_EMR1, 32'h0000_0409);
    wb_xfer(1'b1, ADDR_EMR2, 32'h0000_0080);
    wb_xfer(1'b0, ADDR_EMR2, 32'h0);
    chk("emr2", 32'h0000_0080, rdv);
    // Only the upper lane lands; bits 7..0 keep their value
    sel_v = 4'h2;
    wb_xfer(1'b1, ADDR_EMR3, 32'h0000_1fff);
    sel_v = 4'hf;
    wb_xfer(1'b0, ADDR_EMR3, 32'h0);
    chk("emr3 lane", 32'h0000_1f00, rdv);
    wb_xfer(1'b1, ADDR_EMR3, 32'h0);
    chk("ck pair", {31'h0, ~ck}, {31'h0, ck_n});
    wb_xfer(1'b1, ADDR_CTRL, 32'h1);
    // Busy in the stable wait, state code of that step
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("busy", 32'h0002_0001, rdv);
    wait_done;
    check_seq;
    chk("ready", 32'h1, {31'h0, i_ddrin_mem.ready_r});
    chk("mr kept", 32'h0a42, 32'(i_ddrin_mem.mode_r[0]));
    chk("emr1 kept", 32'h0408, 32'(i_ddrin_mem.mode_r[1]));
    // Restart in mid-sequence; the whole order must replay
    i_ddrin_mem.log_q.delete();
    wb_xfer(1'b1, ADDR_CTRL, 32'h1);
    k = 0;
    while (i_ddrin_mem.log_q.size() < 5 && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    wb_xfer(1'b1, ADDR_CTRL, 32'h1);
    k = 0;
    while (cmd.cke !== 1'b0 && k < 8)
    begin
      @(posedge clk);
      k++;
    end
    chk("cke dropped", 32'h0, {31'h0, cmd.cke});
    i_ddrin_mem.log_q.delete();
    wait_done;
    check_seq;
    test_done;
  end
endmodule
